// >>> src/coo_regs.sv
// Current offset trim and output overvoltage limit command registers
//
// Summary of operation
// - The offset trim at code 39h is written by Write Word, read by Read Word, and acts at once.
// - The offset trim word is an exponent in bits 15:11 resetting to 11100b and a mantissa in 10:0.
// - The configured offset is subtracted from the reported output current.
// - Each phase keeps its own trim and the stack offset is the sum of the trims of the phases below the phase count.
// - Selector 00h-03h below the phase count writes and reads only the chosen phase's trim.
// - Selector FFh writes the total divided by the phase count into every active phase and clears the others.
// - Selector FFh reads phase 00h's trim times the phase count.
// - Out-of-range writes are refused and raise the invalid-data status and alert.
// - Restore reloads each trim from the coarse value kept at the last store; power-up reloads zero, as reset also clears that backup.
// - In operation, trim writes keep full resolution when inside the supported range.
// - The OV limit at code 40h is an unsigned 16-bit word, relative or absolute per format.
// - An OV fault is declared when sensed output voltage reaches the applied limit.
// - The applied limit tracks the target; in absolute format a new target leaves the word alone.
// - OV checking runs from reset release, whether conversion is enabled or not.
// - An OV fault is acted on as the configured reaction setting says.
`timescale 1ns/10ps
`default_nettype none
`include "coo_map.svh"

module coo_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire coo_pkg::coo_cmd_t cmd_i,
    output coo_pkg::coo_rsp_t rsp_o,
    input wire logic [2:0] num_phases_i,
    input wire logic nvm_store_i,
    input wire logic nvm_restore_i,
    input wire logic signed [19:0] current_meas_i,
    output logic signed [19:0] output_current_reading_o,
    input wire logic [15:0] output_voltage_target_i,
    input wire logic output_voltage_format_i,
    input wire logic [15:0] vout_sense_i,
    input wire coo_pkg::coo_react_t overvoltage_reaction_i,
    input wire logic clear_faults_i,
    output logic ov_fault_o,
    output logic ov_status_o,
    output logic cml_status_o,
    output logic alert_o,
    output logic conv_inhibit_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Linear format helpers
    // Word to a signed value in 2^-8 units; exponents beyond reach give a huge value
    // exponent and mantissa fields
    function automatic logic signed [31:0] lin_to_fine(input logic [15:0] word);
        logic signed [4:0] e;
        logic signed [31:0] m;
        int sh;
        e = word[`COO_EXP_HI:`COO_EXP_LO];
        m = 32'(signed'(word[`COO_MAN_HI:`COO_MAN_LO]));
        sh = int'(e) + `COO_FINE_SHIFT;
        if (sh > 12) begin
            lin_to_fine = 32'sh7FFFFFFF;
        end else if (sh >= 0) begin
            lin_to_fine = m <<< sh;
        end else begin
            lin_to_fine = m >>> (-sh);
        end
    endfunction : lin_to_fine

    // Coarse exponent where exact, fine where needed, so the reset code reads back unchanged
    function automatic logic [15:0] fine_to_lin(input logic signed [19:0] v);
        logic signed [19:0] c;
        c = v >>> 4;
        if (v[3:0] == 4'h0 && c >= -20'sd1024 && c <= 20'sd1023) begin
            fine_to_lin = {`COO_OFS_EXP_RST, c[10:0]};
        end else if (v >= -20'sd1024 && v <= 20'sd1023) begin
            fine_to_lin = {`COO_OFS_EXP_FINE, v[10:0]};
        end else begin
            fine_to_lin = {`COO_OFS_EXP_RST, c[10:0]};
        end
    endfunction : fine_to_lin

    // Stack split into equal shares for phase counts of one to four
    function automatic logic signed [31:0] div_phases(input logic signed [31:0] v,
                                                      input logic [2:0] n);
        case (n)
            3'h2: div_phases = v / 2;
            3'h3: div_phases = v / 3;
            3'h4: div_phases = v / 4;
            default: div_phases = v;
        endcase
    endfunction : div_phases

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode
    logic signed [19:0] trim [`COO_NUM_PHASES];
    logic signed [19:0] nvm_trim [`COO_NUM_PHASES];
    logic [15:0] ov_limit;
    logic [15:0] abs_base;
    logic restore_pend;
    logic [2:0] nph;
    logic signed [31:0] wr_fine;
    logic signed [31:0] wr_split;
    logic signed [31:0] rd_total;
    logic is_trim;
    logic is_ov;
    logic phase_one;
    logic phase_all;
    logic trim_ok;
    logic trim_wr;
    logic ov_wr;
    logic bad_cmd;
    logic do_restore;

    always_comb begin
        nph = (num_phases_i == 3'h0 || num_phases_i > 3'h4) ? 3'h1 : num_phases_i;
        is_trim = cmd_i.valid && cmd_i.code == `COO_CMD_OFFSET_TRIM;
        is_ov = cmd_i.valid && cmd_i.code == `COO_CMD_OV_LIMIT;
        phase_one = cmd_i.phase <= `COO_PHASE_MAX && cmd_i.phase < {5'h00, nph};
        phase_all = cmd_i.phase == `COO_PHASE_ALL;
        wr_fine = lin_to_fine(cmd_i.data);
        wr_split = div_phases(wr_fine, nph);
        trim_ok = phase_all ? (wr_split >= -`COO_OFS_LIMIT && wr_split <= `COO_OFS_LIMIT)
            : (wr_fine >= -`COO_OFS_LIMIT && wr_fine <= `COO_OFS_LIMIT);
        trim_wr = is_trim && cmd_i.write && trim_ok && (phase_one || phase_all);
        ov_wr = is_ov && cmd_i.write;
        bad_cmd = cmd_i.valid && !(ov_wr || trim_wr || (is_ov && !cmd_i.write)
            || (is_trim && !cmd_i.write && (phase_one || phase_all)));
        do_restore = restore_pend || nvm_restore_i;
        rd_total = 32'(trim[0]) * 32'(nph);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trim storage and backup
    // The first cycle after reset acts as the power-on restore
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            restore_pend <= 1'b1;
        end else begin
            restore_pend <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < `COO_NUM_PHASES; i++) begin
                trim[i] <= `COO_NVM_RST;
            end
        end else if (do_restore) begin
            for (int i = 0; i < `COO_NUM_PHASES; i++) begin
                trim[i] <= nvm_trim[i];
            end
        end else if (trim_wr) begin
            for (int i = 0; i < `COO_NUM_PHASES; i++) begin
                if (phase_all) begin
                    trim[i] <= (i < int'(nph)) ? wr_split[19:0] : `COO_NVM_RST;
                end else if (cmd_i.phase[1:0] == 2'(i)) begin
                    trim[i] <= wr_fine[19:0];
                end
            end
        end
    end
    // Backup keeps only coarse steps; finer bits are dropped toward minus infinity
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < `COO_NUM_PHASES; i++) begin
                nvm_trim[i] <= `COO_NVM_RST;
            end
        end else if (nvm_store_i) begin
            for (int i = 0; i < `COO_NUM_PHASES; i++) begin
                nvm_trim[i] <= (trim[i] >>> `COO_NVM_STEP_BITS) <<< `COO_NVM_STEP_BITS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Current reading correction
    logic signed [21:0] stack_offset;
    logic signed [21:0] corrected;
    always_comb begin
        stack_offset = 22'sd0;
        for (int i = 0; i < `COO_NUM_PHASES; i++) begin
            if (i < int'(nph)) begin
                stack_offset = stack_offset + 22'(trim[i]);
            end
        end
        corrected = 22'(current_meas_i) - stack_offset;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            output_current_reading_o <= 20'sd0;
        end else if (corrected > 22'sd524287) begin
            output_current_reading_o <= 20'sh7FFFF;
        end else if (corrected < -22'sd524288) begin
            output_current_reading_o <= 20'sh80000;
        end else begin
            output_current_reading_o <= corrected[19:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Overvoltage limit register and applied threshold
    // limit word
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ov_limit <= `COO_OV_LIMIT_RST;
        end else if (ov_wr) begin
            ov_limit <= cmd_i.data;
        end
    end
    // Target at the time the absolute limit was set, so the margin follows later targets
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            abs_base <= 16'h0000;
        end else if (restore_pend) begin
            abs_base <= output_voltage_target_i;
        end else if (ov_wr) begin
            abs_base <= output_voltage_target_i;
        end
    end
    logic [31:0] rel_prod;
    logic signed [18:0] abs_thr;
    logic [17:0] ov_thr;
    always_comb begin
        rel_prod = (32'(output_voltage_target_i) * 32'(ov_limit)) >> `COO_OV_REL_BITS;
        abs_thr = 19'(output_voltage_target_i) + 19'(ov_limit) - 19'(abs_base);
        if (output_voltage_format_i) begin
            ov_thr = (rel_prod > 32'h0003FFFF) ? 18'h3FFFF : rel_prod[17:0];
        end else if (abs_thr < 19'sd0) begin
            ov_thr = 18'h00000;
        end else begin
            ov_thr = abs_thr[17:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Overvoltage detection and reaction
    logic ov_hit;
    coo_pkg::coo_ov_state_t ov_state;
    coo_pkg::coo_ov_state_t next_ov_state;
    logic [`COO_RETRY_W-1:0] retry_cnt;
    assign ov_hit = {2'h0, vout_sense_i} >= ov_thr;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ov_fault_o <= 1'b0;
        end else begin
            ov_fault_o <= ov_hit;
        end
    end
    always_comb begin
        next_ov_state = ov_state;
        case (ov_state)
            coo_pkg::COO_OV_RUN: begin
                if (ov_hit && overvoltage_reaction_i == coo_pkg::COO_REACT_LATCH) begin
                    next_ov_state = coo_pkg::COO_OV_LATCHED;
                end else if (ov_hit && overvoltage_reaction_i == coo_pkg::COO_REACT_RETRY) begin
                    next_ov_state = coo_pkg::COO_OV_RETRY;
                end
            end
            coo_pkg::COO_OV_LATCHED: begin
                if (clear_faults_i && !ov_hit) begin
                    next_ov_state = coo_pkg::COO_OV_RUN;
                end
            end
            coo_pkg::COO_OV_RETRY: begin
                if (retry_cnt == `COO_RETRY_W'(`COO_OV_RETRY_CYC - 1)) begin
                    next_ov_state = coo_pkg::COO_OV_RUN;
                end
            end
            default: begin
                next_ov_state = coo_pkg::COO_OV_RUN;
            end
        endcase
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ov_state <= coo_pkg::COO_OV_RUN;
        end else begin
            ov_state <= next_ov_state;
        end
    end
    // Retry wait restarts while the fault persists, but a fault in the last wait cycle still lets conversion resume for one cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            retry_cnt <= '0;
        end else if (ov_state != coo_pkg::COO_OV_RETRY || ov_hit) begin
            retry_cnt <= '0;
        end else begin
            retry_cnt <= retry_cnt + `COO_RETRY_W'(1);
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            conv_inhibit_o <= 1'b0;
        end else begin
            conv_inhibit_o <= next_ov_state != coo_pkg::COO_OV_RUN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status and alert; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ov_status_o <= 1'b0;
        end else if (ov_hit) begin
            ov_status_o <= 1'b1;
        end else if (clear_faults_i) begin
            ov_status_o <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cml_status_o <= 1'b0;
        end else if (bad_cmd) begin
            cml_status_o <= 1'b1;
        end else if (clear_faults_i) begin
            cml_status_o <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            alert_o <= 1'b0;
        end else if (bad_cmd || ov_hit) begin
            alert_o <= 1'b1;
        end else if (clear_faults_i) begin
            alert_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Answer to each transaction
    // stack total read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.valid <= cmd_i.valid;
            rsp_o.err <= bad_cmd;
            if (!cmd_i.valid || cmd_i.write || bad_cmd) begin
                rsp_o.data <= 16'h0000;
            end else if (is_ov) begin
                rsp_o.data <= ov_limit;
            end else if (phase_all) begin
                rsp_o.data <= fine_to_lin(rd_total[19:0]);
            end else begin
                rsp_o.data <= fine_to_lin(trim[cmd_i.phase[1:0]]);
            end
        end
    end

endmodule : coo_regs

`default_nettype wire

// >>> src/coo_map.svh
// Command codes, field positions, reset values and timing counts of the offset and OV bank
`ifndef COO_MAP_SVH
`define COO_MAP_SVH
`define COO_CMD_OFFSET_TRIM 8'h39
`define COO_CMD_OV_LIMIT 8'h40
`define COO_EXP_HI 15
`define COO_EXP_LO 11
`define COO_MAN_HI 10
`define COO_MAN_LO 0
`define COO_OFS_EXP_RST 5'h1C
`define COO_OFS_EXP_FINE 5'h18
`define COO_PHASE_MAX 8'h03
`define COO_PHASE_ALL 8'hFF
`define COO_NUM_PHASES 4
`define COO_FINE_SHIFT 8
`define COO_OFS_LIMIT 32'sh000003E8
`define COO_NVM_STEP_BITS 4
`define COO_NVM_RST 20'h00000
`define COO_OV_LIMIT_RST 16'h0299
`define COO_OV_REL_BITS 9
`define COO_CLK_MHZ 125
`define COO_OV_RETRY_NS 1000
`define COO_OV_RETRY_CYC ((`COO_OV_RETRY_NS * `COO_CLK_MHZ) / 1000)
`define COO_RETRY_W 8
`endif

// >>> src/coo_pkg.sv
// Types shared by the offset trim and overvoltage limit bank
package coo_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] phase;
        logic [15:0] data;
    } coo_cmd_t;
    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] data;
    } coo_rsp_t;
    typedef enum logic [1:0] {
        COO_REACT_IGNORE = 2'h0,
        COO_REACT_LATCH = 2'h1,
        COO_REACT_RETRY = 2'h2
    } coo_react_t;
    typedef enum logic [2:0] {
        COO_OV_RUN = 3'h1,
        COO_OV_LATCHED = 3'h2,
        COO_OV_RETRY = 3'h4
    } coo_ov_state_t;
endpackage : coo_pkg

// >>> testbench/coo_regs_asserts.sv
// Port-level concurrent checks for the offset trim and overvoltage limit bank
`timescale 1ns/10ps
`default_nettype none
module coo_regs_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire coo_pkg::coo_cmd_t cmd_i,
    input wire coo_pkg::coo_rsp_t rsp_o,
    input wire coo_pkg::coo_react_t overvoltage_reaction_i,
    input wire logic clear_faults_i,
    input wire logic ov_fault_o,
    input wire logic ov_status_o,
    input wire logic cml_status_o,
    input wire logic alert_o,
    input wire logic conv_inhibit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_refused; rsp_o.valid && rsp_o.err; endsequence
    // Retry must hold conversion off well past the end of the overvoltage
    sequence s_hold; conv_inhibit_o [*8]; endsequence
    property p_rsp; cmd_i.valid |=> rsp_o.valid; endproperty
    a_rsp: assert property (p_rsp) else $error("no response after command");
    property p_code; cmd_i.valid && !(cmd_i.code inside {8'h39, 8'h40}) |=> s_refused; endproperty
    a_code: assert property (p_code) else $error("unknown code accepted");
    property p_phase;
        cmd_i.valid && cmd_i.code == 8'h39 && cmd_i.phase inside {[8'h04:8'hFE]} |=> s_refused;
    endproperty
    a_phase: assert property (p_phase) else $error("bad phase accepted");
    property p_flag; s_refused |-> ##[0:1] (cml_status_o && alert_o); endproperty
    a_flag: assert property (p_flag) else $error("refusal not flagged");
    property p_wdata; rsp_o.valid && $past(cmd_i.write) |-> rsp_o.data == 16'h0000; endproperty
    a_wdata: assert property (p_wdata) else $error("write answer carries data");
    property p_ovst; ov_fault_o |-> ##[0:1] ov_status_o; endproperty
    a_ovst: assert property (p_ovst) else $error("overvoltage status missing");
    property p_trip;
        ov_fault_o && overvoltage_reaction_i == coo_pkg::COO_REACT_LATCH |-> ##[0:1] conv_inhibit_o;
    endproperty
    a_trip: assert property (p_trip) else $error("latch reaction did not stop");
    property p_latch;
        conv_inhibit_o && overvoltage_reaction_i == coo_pkg::COO_REACT_LATCH && !clear_faults_i
            |=> conv_inhibit_o;
    endproperty
    a_latch: assert property (p_latch) else $error("latched stop released");
    property p_ign;
        overvoltage_reaction_i == coo_pkg::COO_REACT_IGNORE && !conv_inhibit_o |=> !conv_inhibit_o;
    endproperty
    a_ign: assert property (p_ign) else $error("ignore reaction stopped");
    property p_retry;
        $fell(ov_fault_o) && overvoltage_reaction_i == coo_pkg::COO_REACT_RETRY |-> s_hold;
    endproperty
    a_retry: assert property (p_retry) else $error("retry wait cut short");
endmodule : coo_regs_asserts
bind coo_regs coo_regs_asserts u_chk (.clk_i, .rst_i, .cmd_i, .rsp_o, .overvoltage_reaction_i,
    .clear_faults_i, .ov_fault_o, .ov_status_o, .cml_status_o, .alert_o, .conv_inhibit_o);
`default_nettype wire

// >>> testbench/coo_host.sv
// Command host model issuing word transfers to the bank
`timescale 1ns/10ps
`default_nettype none
module coo_host (
    input wire logic clk_i,
    input wire coo_pkg::coo_rsp_t rsp_i,
    output var coo_pkg::coo_cmd_t cmd_o
);
    initial cmd_o = '0;
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p,
                        input logic [15:0] d, output logic [15:0] rd, output logic e,
                        output logic ok);
        ok = 1'b0;
        rd = 16'h0000;
        e = 1'b0;
        @(posedge clk_i);
        #1;
        cmd_o = '{1'b1, w, c, p, d};
        @(posedge clk_i);
        #1;
        // Released fields flip so a stale word never looks live
        cmd_o = '{1'b0, ~w, ~c, ~p, ~d};
        for (int i = 0; i < 2 && !ok; i++) begin
            if (rsp_i.valid === 1'b1) begin
                ok = 1'b1;
                rd = rsp_i.data;
                e = rsp_i.err;
            end else begin
                @(posedge clk_i);
                #1;
            end
        end
    endtask : xfer
endmodule : coo_host
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the offset trim and overvoltage limit bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    $display("unexpected %s exp %h got %h", nm, ex, got); n_mismatch++; end end
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    coo_pkg::coo_cmd_t cmd;
    coo_pkg::coo_rsp_t rsp;
    logic [2:0] nph = 3'h4;
    logic st = 1'b0, rs = 1'b0, clr = 1'b0, fmt = 1'b0;
    logic signed [19:0] meas = 20'sh003E8, rdg;
    logic [15:0] tgt = 16'h03E8, sense = 16'h02BC;
    coo_pkg::coo_react_t react = coo_pkg::COO_REACT_IGNORE;
    logic ovf, ovs, cml, alrt, inh;
    int n_mismatch = 0;
    int n_compared = 0;
    always #4 clk_i = ~clk_i;
    coo_host host (.clk_i(clk_i), .rsp_i(rsp), .cmd_o(cmd));
    coo_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .rsp_o(rsp), .num_phases_i(nph),
        .nvm_store_i(st), .nvm_restore_i(rs), .current_meas_i(meas),
        .output_current_reading_o(rdg), .output_voltage_target_i(tgt),
        .output_voltage_format_i(fmt), .vout_sense_i(sense), .overvoltage_reaction_i(react),
        .clear_faults_i(clr), .ov_fault_o(ovf), .ov_status_o(ovs), .cml_status_o(cml),
        .alert_o(alrt), .conv_inhibit_o(inh));
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic xf(input logic w, input logic [7:0] c, input logic [7:0] p,
                      input logic [15:0] d, output logic [15:0] r, output logic e);
        logic ok;
        host.xfer(w, c, p, d, r, e, ok);
        if (ok !== 1'b1) begin
            n_mismatch++;
            final_report();
        end
    endtask : xf
    task automatic wr(input logic [7:0] c, input logic [7:0] p, input logic [15:0] d,
                      input logic ee);
        logic [15:0] r;
        logic e;
        xf(1'b1, c, p, d, r, e);
        `CHK("refusal", ee, e)
    endtask : wr
    task automatic rd_chk(input logic [7:0] c, input logic [7:0] p, input logic [15:0] x);
        logic [15:0] r;
        logic e;
        xf(1'b0, c, p, 16'h0000, r, e);
        `CHK("read word", x, r)
    endtask : rd_chk
    // Fault output is registered one cycle after the compare
    task automatic ov_at(input logic [15:0] v, input logic x);
        sense = v;
        cyc(2);
        `CHK("ov_fault", x, ovf)
    endtask : ov_at
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK("ov_fault", 1'b1, ovf)
        rd_chk(8'h39, 8'h00, 16'hE000);
        rd_chk(8'h40, 8'h00, 16'h0299);
        sense = 16'h0000;
        $display("t_reset done");
    endtask : t_reset
    task automatic t_trim();
        for (int k = 0; k < 4; k++) wr(8'h39, 8'(k), {5'h1C, 11'(k + 1)}, 1'b0);
        for (int k = 0; k < 4; k++) rd_chk(8'h39, 8'(k), {5'h1C, 11'(k + 1)});
        rd_chk(8'h39, 8'hFF, 16'hE004);
        cyc(2);
        `CHK("reading", 20'sh00348, rdg)
        wr(8'h39, 8'hFF, 16'hE008, 1'b0);
        rd_chk(8'h39, 8'h03, 16'hE002);
        rd_chk(8'h39, 8'hFF, 16'hE008);
        cyc(2);
        `CHK("reading", 20'sh00368, rdg)
        $display("t_trim done");
    endtask : t_trim
    task automatic t_refuse();
        // Clear earlier overvoltage alerts so the refusal alone must raise it
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        `CHK("alert", 1'b0, alrt)
        wr(8'h39, 8'h00, 16'hE07F, 1'b1);
        cyc(1);
        `CHK("cml", 1'b1, cml)
        `CHK("alert", 1'b1, alrt)
        rd_chk(8'h39, 8'h00, 16'hE002);
        wr(8'h41, 8'h00, 16'h0000, 1'b1);
        wr(8'h39, 8'h04, 16'hE001, 1'b1);
        nph = 3'h2;
        wr(8'h39, 8'h02, 16'hE001, 1'b1);
        nph = 3'h4;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(1);
        `CHK("cml", 1'b0, cml)
        `CHK("alert", 1'b0, alrt)
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_nvm();
        wr(8'h39, 8'h00, 16'hC028, 1'b0);
        rd_chk(8'h39, 8'h00, 16'hC028);
        st = 1'b1;
        cyc(1);
        st = 1'b0;
        wr(8'h39, 8'hFF, 16'hE000, 1'b0);
        rs = 1'b1;
        cyc(1);
        rs = 1'b0;
        rd_chk(8'h39, 8'h00, 16'hE002);
        rd_chk(8'h39, 8'h01, 16'hE002);
        $display("t_nvm done");
    endtask : t_nvm
    task automatic t_ov();
        react = coo_pkg::COO_REACT_LATCH;
        wr(8'h40, 8'h00, 16'h044C, 1'b0);
        rd_chk(8'h40, 8'h00, 16'h044C);
        ov_at(16'h044B, 1'b0);
        ov_at(16'h044C, 1'b1);
        `CHK("ov_status", 1'b1, ovs)
        ov_at(16'h0000, 1'b0);
        `CHK("inhibit", 1'b1, inh)
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(1);
        `CHK("inhibit", 1'b0, inh)
        tgt = 16'h04B0;
        rd_chk(8'h40, 8'h00, 16'h044C);
        ov_at(16'h04E2, 1'b0);
        react = coo_pkg::COO_REACT_RETRY;
        ov_at(16'h0514, 1'b1);
        ov_at(16'h0000, 1'b0);
        `CHK("inhibit", 1'b1, inh)
        cyc(130);
        `CHK("inhibit", 1'b0, inh)
        react = coo_pkg::COO_REACT_IGNORE;
        fmt = 1'b1;
        tgt = 16'h0200;
        wr(8'h40, 8'h00, 16'h0240, 1'b0);
        ov_at(16'h023F, 1'b0);
        ov_at(16'h0240, 1'b1);
        `CHK("inhibit", 1'b0, inh)
        $display("t_ov done");
    endtask : t_ov
    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        cyc(2);
        t_reset();
        t_trim();
        t_refuse();
        t_nvm();
        t_ov();
        final_report();
    end
endmodule : tb
`default_nettype wire
